//--- io_pin_drive_mode_control.sv
`timescale 1ns/10ps
`default_nettype none
// How it works
// R1 - Each pin has own three-bit mode
// R2 - Mode 0 disables driver and input buffer
// R3 - Mode 1 input buffer only, driver off
// R4 - Modes 2,3 resistive one side, strong other
// R5 - Modes 4,5 open drain low or high
// R6 - Mode 6 strong drive both levels
// R7 - Mode 7 resistive up and down
// R8 - Resistive, open-drain modes keep input enabled
// R9 - Regulated special pins lose resistive modes
// R10 - Drive value from output reg or bypass
// R11 - Separate pin-state read from output register
// R12 - Per-pin rising, falling, both, none edges
// R13 - One interrupt request per port
// R14 - No level interrupts generated here
// R15 - Port-wide and per-pin writes share state
// R16 - Modes loaded from programmable reset state
// R17 - Data reachable by processor, DMA, fabric
// R18 - Edge event sets status bit, raises request
// R19 - Aux output enable selects digital high-Z
// R20 - Inputs synchronised before use
// R21 - Status read clears returned bits
module io_pin_drive_mode_control
	import io_port_pkg::*;
#(
	parameter int PINS = PIN_COUNT
)
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [PINS*MODE_WIDTH-1:0] resetModes,
	input wire logic portModeWe,
	input wire logic [PINS*MODE_WIDTH-1:0] portModeWdata,
	input wire logic pinModeWe,
	input wire logic [$clog2(PINS)-1:0] pinModeSel,
	input wire logic [MODE_WIDTH-1:0] pinModeWdata,
	input wire logic outWe,
	input wire logic [PINS-1:0] outWdata,
	input wire logic pinOutWe,
	input wire logic pinOutWdata,
	input wire logic [PINS-1:0] bypassSel,
	input wire logic [PINS-1:0] fabricOut,
	input wire logic [PINS-1:0] auxOutEnable,
	input wire logic [PINS-1:0] regulatedHigh,
	input wire logic [2*PINS-1:0] edgeSel,
	input wire logic [PINS-1:0] pinIn,
	input wire logic statusRead,
	output logic [PINS*MODE_WIDTH-1:0] port_drive_mode_regs,
	output logic [PINS-1:0] port_output_value_reg,
	output logic [PINS-1:0] pin_state_read_reg,
	output logic [PINS-1:0] fabricIn,
	output logic [PINS-1:0] irqStatus,
	output logic [PINS-1:0] statusReadData,
	output logic portIrq,
	output logic [PINS-1:0] strongHighEn,
	output logic [PINS-1:0] strongLowEn,
	output logic [PINS-1:0] resHighEn,
	output logic [PINS-1:0] resLowEn,
	output logic [PINS-1:0] inBufEn
);
	initial
	begin
		if (PINS < 2 || PINS > 16)
			$error("PINS must be 2..16");
	end

	typedef struct packed {
		logic [PINS*MODE_WIDTH-1:0] modes;
		logic [PINS-1:0] outVal;
		logic [PINS-1:0] pinState;
		logic [PINS-1:0] status;
		logic [PINS-1:0] readData;
		logic irq;
		logic loaded;
		logic [PINS-1:0] sHi;
		logic [PINS-1:0] sLo;
		logic [PINS-1:0] rHi;
		logic [PINS-1:0] rLo;
		logic [PINS-1:0] ibuf;
	} port_t;
	port_t st_r;
	port_t st_nxt;

	logic [PINS-1:0] syncIn;
	logic [PINS-1:0] edgeEv;
	logic [PINS-1:0] driveVal;
	logic [PINS-1:0] dSHi;
	logic [PINS-1:0] dSLo;
	logic [PINS-1:0] dRHi;
	logic [PINS-1:0] dRLo;
	logic [PINS-1:0] dIbuf;
	logic [PINS-1:0] statusAfter;

	genvar g;
	generate
		for (g = 0; g < PINS; g++)
		begin : pinGen
			// Drive value: register bit or fabric bypass
			assign driveVal[g] = bypassSel[g] ? fabricOut[g] : st_r.outVal[g]; // see R10
			pin_drive_decode decodeInst (
				.pin_drive_mode_field(st_r.modes[g*MODE_WIDTH +: MODE_WIDTH]), // see R1
				.outValue(driveVal[g]),
				.outEnable(auxOutEnable[g]),
				.regulatedHigh(regulatedHigh[g]),
				.strongHighEn(dSHi[g]),
				.strongLowEn(dSLo[g]),
				.resHighEn(dRHi[g]),
				.resLowEn(dRLo[g]),
				.inBufEn(dIbuf[g])
			);
			pin_edge_detect edgeInst (
				.clk_sys(clk_sys),
				.rst_n(rst_n),
				.pinRaw(pinIn[g]),
				.edgeSel(edgeSel[2*g +: 2]),
				.pinSync(syncIn[g]),
				.edgeEvent(edgeEv[g]) // see R12, R14
			);
		end
	endgenerate

	always_comb
	begin
		st_nxt = st_r;
		// Catch the strap once after reset release
		if (!st_r.loaded)
		begin
			st_nxt.modes = resetModes; // see R16
			st_nxt.loaded = 1'b1;
		end
		else if (portModeWe)
			st_nxt.modes = portModeWdata; // see R15
		else if (pinModeWe)
			st_nxt.modes[pinModeSel*MODE_WIDTH +: MODE_WIDTH] = pinModeWdata; // see R15
		if (outWe)
			st_nxt.outVal = outWdata; // see R17
		else if (pinOutWe)
			st_nxt.outVal[pinModeSel] = pinOutWdata; // see R15
		// Disabled input buffer reads zero
		st_nxt.pinState = syncIn & dIbuf; // see R11, R20
		// Read clears returned bits; new events win
		statusAfter = statusRead ? '0 : st_r.status; // see R21
		st_nxt.status = statusAfter | (edgeEv & dIbuf); // see R18
		st_nxt.readData = statusRead ? st_r.status : st_r.readData;
		st_nxt.irq = |st_nxt.status; // see R13
		st_nxt.sHi = dSHi;
		st_nxt.sLo = dSLo;
		st_nxt.rHi = dRHi;
		st_nxt.rLo = dRLo;
		st_nxt.ibuf = dIbuf;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_r <= '0;
			st_r.outVal <= PORT_OUTPUT_RESET;
			st_r.status <= STATUS_RESET;
		end
		else
			st_r <= st_nxt;
	end

	assign port_drive_mode_regs = st_r.modes;
	assign port_output_value_reg = st_r.outVal;
	assign pin_state_read_reg = st_r.pinState;
	assign fabricIn = st_r.pinState; // see R17
	assign irqStatus = st_r.status;
	assign statusReadData = st_r.readData;
	assign portIrq = st_r.irq;
	assign strongHighEn = st_r.sHi;
	assign strongLowEn = st_r.sLo;
	assign resHighEn = st_r.rHi;
	assign resLowEn = st_r.rLo;
	assign inBufEn = st_r.ibuf;

	irq_follows_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		portIrq == (|irqStatus)) else $error("irq not matching status"); // see R13
	status_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(edgeEv & dIbuf) != '0 |=> (irqStatus & $past(edgeEv & dIbuf)) == $past(edgeEv & dIbuf))
		else $error("edge event lost"); // see R18
	read_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		statusRead && (edgeEv & dIbuf) == '0 |=> irqStatus == '0 && statusReadData == $past(irqStatus))
		else $error("status read did not clear"); // see R21
	strap_load_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!st_r.loaded |=> port_drive_mode_regs == $past(resetModes)) else $error("strap not loaded"); // see R16
	no_contention_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(strongHighEn & strongLowEn) == '0 && (strongHighEn & resLowEn) == '0)
		else $error("driver contention"); // see R4
	oe_off_hiz_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		auxOutEnable != '1 |=> ((strongHighEn | strongLowEn | resHighEn | resLowEn)
		& ~$past(auxOutEnable)) == '0) else $error("driver on while oe low"); // see R19
	regulated_res_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		##1 ((resHighEn | resLowEn) & $past(regulatedHigh)) == '0)
		else $error("resistive drive in regulated mode"); // see R9
	pin_state_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		##1 pin_state_read_reg == ($past(syncIn) & $past(dIbuf))) else $error("pin state wrong"); // see R11
	out_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		outWe |=> port_output_value_reg == $past(outWdata)) else $error("output write lost"); // see R17
endmodule
`default_nettype wire

//--- io_pin_drive_mode_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
module io_pin_drive_mode_control_tb;
	import io_port_pkg::*;
	logic clk_sys, rst_n, portModeWe, pinModeWe, outWe, pinOutWe, pinOutWdata, statusRead;
	logic [23:0] resetModes, portModeWdata, portModes, expModes;
	logic [2:0] pinModeSel, pinModeWdata;
	logic [7:0] outWdata, bypassSel, fabricOut, auxOutEnable, regulatedHigh, pinIn, extDrive;
	logic [7:0] extLevel, outVal, pinState, fabricIn, irqStatus, statusReadData, expOut;
	logic [7:0] strongHighEn, strongLowEn, resHighEn, resLowEn, inBufEn;
	logic [15:0] edgeSel;
	logic portIrq;
	int miscompares = 0;
	int n_tests = 0;
	io_pin_drive_mode_control DUT (.clk_sys(clk_sys), .rst_n(rst_n), .resetModes(resetModes),
		.portModeWe(portModeWe), .portModeWdata(portModeWdata), .pinModeWe(pinModeWe),
		.pinModeSel(pinModeSel), .pinModeWdata(pinModeWdata), .outWe(outWe),
		.outWdata(outWdata), .pinOutWe(pinOutWe), .pinOutWdata(pinOutWdata),
		.bypassSel(bypassSel), .fabricOut(fabricOut), .auxOutEnable(auxOutEnable),
		.regulatedHigh(regulatedHigh), .edgeSel(edgeSel), .pinIn(pinIn),
		.statusRead(statusRead), .port_drive_mode_regs(portModes),
		.port_output_value_reg(outVal), .pin_state_read_reg(pinState), .fabricIn(fabricIn),
		.irqStatus(irqStatus), .statusReadData(statusReadData), .portIrq(portIrq),
		.strongHighEn(strongHighEn), .strongLowEn(strongLowEn), .resHighEn(resHighEn),
		.resLowEn(resLowEn), .inBufEn(inBufEn));
	pin_load_model load (.clk_sys(clk_sys), .strongHighEn(strongHighEn),
		.strongLowEn(strongLowEn), .resHighEn(resHighEn), .resLowEn(resLowEn),
		.extDrive(extDrive), .extLevel(extLevel), .pinIn(pinIn));
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic chk(input string name, input logic [39:0] exp, input logic [39:0] got);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Expected {strongHigh, strongLow, resHigh, resLow, inBuf} of one pin
	function automatic logic [4:0] drv(input logic [2:0] m, input logic v, input logic rg);
		logic [4:0] r;
		case (m)
			3'h0: r = 5'h00;
			3'h1: r = 5'h01;
			3'h2: r = v ? 5'h05 : 5'h09;
			3'h3: r = v ? 5'h11 : 5'h03;
			3'h4: r = v ? 5'h01 : 5'h09;
			3'h5: r = v ? 5'h11 : 5'h01;
			3'h6: r = v ? 5'h11 : 5'h09;
			default: r = v ? 5'h05 : 5'h03;
		endcase
		if (rg)
			r[2:1] = 2'h0;
		return r;
	endfunction
	task automatic chkDrv();
		logic [4:0] e;
		logic [39:0] x;
		for (int i = 0; i < 8; i++)
		begin
			e = drv(auxOutEnable[i] ? expModes[3*i+:3] : MODE_HIZ_DIGITAL,
				bypassSel[i] ? fabricOut[i] : expOut[i], regulatedHigh[i]);
			for (int k = 0; k < 5; k++)
				x[8*k+i] = e[k];
		end
		chk("drive", x, {strongHighEn, strongLowEn, resHighEn, resLowEn, inBufEn});
	endtask
	task automatic results();
		$display("Comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		#20000;
		miscompares++;
		results();
	end
	initial
	begin
		{rst_n, portModeWe, pinModeWe, outWe, pinOutWe, pinOutWdata, statusRead} = 7'h00;
		{portModeWdata, pinModeSel, pinModeWdata, outWdata} = 38'h0;
		{bypassSel, fabricOut, regulatedHigh, extLevel, edgeSel} = 48'h0;
		auxOutEnable = 8'hFF;
		extDrive = 8'hFF;
		resetModes = 24'hFA_C688;
		expModes = 24'hFA_C688;
		expOut = 8'h00;
		step(10);
		rst_n = 1'b1;
		step(3);
		chk("modes", expModes, portModes);
		chkDrv();
		outWe = 1'b1;
		outWdata = 8'hFF;
		pinOutWe = 1'b1;
		step(1);
		{outWe, pinOutWe} = 2'h0;
		expOut = 8'hFF;
		step(2);
		chkDrv();
		bypassSel = 8'h0F;
		step(2);
		chkDrv();
		regulatedHigh = 8'hFF;
		step(2);
		chkDrv();
		{regulatedHigh, bypassSel} = 16'h0;
		auxOutEnable = 8'h5A;
		step(2);
		chkDrv();
		auxOutEnable = 8'hFF;
		portModeWe = 1'b1;
		portModeWdata = 24'h24_9249;
		{pinModeWe, pinModeSel, pinModeWdata} = 7'h7E;
		step(1);
		expModes = 24'h24_9249;
		chk("portwins", expModes, portModes);
		portModeWe = 1'b0;
		step(1);
		pinModeWe = 1'b0;
		expModes[21+:3] = MODE_STRONG;
		chk("pinwrite", expModes, portModes);
		expModes[21+:3] = MODE_HIZ_DIGITAL;
		portModeWe = 1'b1;
		step(1);
		portModeWe = 1'b0;
		extLevel = 8'h55;
		edgeSel = 16'hFA50;
		step(4);
		chk("pinstate", 40'h55, pinState);
		chk("fabricin", 40'h55, fabricIn);
		chk("outkept", 40'hFF, outVal);
		pinOutWe = 1'b1;
		pinModeSel = 3'h2;
		step(1);
		pinOutWe = 1'b0;
		chk("pinout", 40'hFB, outVal);
		statusRead = 1'b1;
		step(1);
		statusRead = 1'b0;
		extLevel = 8'hAA;
		step(4);
		chk("status", 40'hD8, irqStatus);
		chk("irq", 40'h1, portIrq);
		statusRead = 1'b1;
		step(1);
		statusRead = 1'b0;
		chk("readdata", 40'hD8, statusReadData);
		chk("cleared", 40'h0, {irqStatus, portIrq});
		results();
	end
endmodule
`default_nettype wire

//--- io_port_pkg.sv
package io_port_pkg;
	localparam int PIN_COUNT = 8;
	localparam int MODE_WIDTH = 3;
	localparam logic [2:0] MODE_HIZ_ANALOG = 3'h0;
	localparam logic [2:0] MODE_HIZ_DIGITAL = 3'h1;
	localparam logic [2:0] MODE_RES_PULL_UP = 3'h2;
	localparam logic [2:0] MODE_RES_PULL_DOWN = 3'h3;
	localparam logic [2:0] MODE_OPEN_DRAIN_LOW = 3'h4;
	localparam logic [2:0] MODE_OPEN_DRAIN_HIGH = 3'h5;
	localparam logic [2:0] MODE_STRONG = 3'h6;
	localparam logic [2:0] MODE_RES_BOTH = 3'h7;
	localparam logic [1:0] EDGE_NONE = 2'h0;
	localparam logic [1:0] EDGE_RISING = 2'h1;
	localparam logic [1:0] EDGE_FALLING = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	localparam logic [7:0] PORT_OUTPUT_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;
endpackage

//--- pin_drive_decode.sv
`timescale 1ns/10ps
`default_nettype none
module pin_drive_decode
	import io_port_pkg::*;
(
	input wire logic [2:0] pin_drive_mode_field,
	input wire logic outValue,
	input wire logic outEnable,
	input wire logic regulatedHigh,
	output logic strongHighEn,
	output logic strongLowEn,
	output logic resHighEn,
	output logic resLowEn,
	output logic inBufEn
);
	logic [2:0] effMode;
	always_comb
	begin
		// Aux output enable low forces high impedance digital
		effMode = outEnable ? pin_drive_mode_field : MODE_HIZ_DIGITAL; // see R19
		strongHighEn = 1'b0;
		strongLowEn = 1'b0;
		resHighEn = 1'b0;
		resLowEn = 1'b0;
		inBufEn = 1'b1; // see R8
		unique case (effMode)
			MODE_HIZ_ANALOG: inBufEn = 1'b0; // see R2
			MODE_HIZ_DIGITAL: inBufEn = 1'b1; // see R3
			MODE_RES_PULL_UP:
			begin
				resHighEn = outValue & ~regulatedHigh; // see R4, R9
				strongLowEn = ~outValue;
			end
			MODE_RES_PULL_DOWN:
			begin
				strongHighEn = outValue; // see R4
				resLowEn = ~outValue & ~regulatedHigh; // see R9
			end
			MODE_OPEN_DRAIN_LOW: strongLowEn = ~outValue; // see R5
			MODE_OPEN_DRAIN_HIGH: strongHighEn = outValue; // see R5
			MODE_STRONG:
			begin
				strongHighEn = outValue; // see R6
				strongLowEn = ~outValue;
			end
			MODE_RES_BOTH:
			begin
				resHighEn = outValue & ~regulatedHigh; // see R7, R9
				resLowEn = ~outValue & ~regulatedHigh;
			end
		endcase
	end
endmodule
`default_nettype wire

//--- pin_edge_detect.sv
`timescale 1ns/10ps
`default_nettype none
module pin_edge_detect
	import io_port_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic pinRaw,
	input wire logic [1:0] edgeSel,
	output logic pinSync,
	output logic edgeEvent
);
	typedef struct packed {
		logic meta;
		logic sync;
		logic prev;
		logic [2:0] warm;
	} sync_t;
	sync_t st_r;
	sync_t st_nxt;
	always_comb
	begin
		st_nxt.meta = pinRaw; // see R20
		st_nxt.sync = st_r.meta;
		st_nxt.prev = st_r.sync;
		// No events until prev holds a real pin level
		st_nxt.warm = {st_r.warm[1:0], 1'b1};
	end
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end
	assign pinSync = st_r.sync;
	always_comb
	begin
		unique case (edgeSel)
			EDGE_NONE: edgeEvent = 1'b0; // see R12
			EDGE_RISING: edgeEvent = st_r.sync & ~st_r.prev & st_r.warm[2];
			EDGE_FALLING: edgeEvent = ~st_r.sync & st_r.prev & st_r.warm[2];
			EDGE_BOTH: edgeEvent = (st_r.sync ^ st_r.prev) & st_r.warm[2];
		endcase
	end
	sync_order_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		st_r.sync == $past(pinRaw, 2)) else $error("pin sync not two stages"); // see R20
endmodule
`default_nettype wire

//--- pin_load_model.sv
`timescale 1ns/10ps
`default_nettype none
module pin_load_model
(
	input wire logic clk_sys,
	input wire logic [7:0] strongHighEn,
	input wire logic [7:0] strongLowEn,
	input wire logic [7:0] resHighEn,
	input wire logic [7:0] resLowEn,
	input wire logic [7:0] extDrive,
	input wire logic [7:0] extLevel,
	output logic [7:0] pinIn
);
	// An undriven pin wanders, so a stale level never reads back
	logic float_r = 1'b0;
	always_ff @(posedge clk_sys)
	begin
		float_r <= ~float_r;
	end
	// Strong beats outside drive, which beats the 5K resistors
	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			pinIn[i] = strongHighEn[i] ? 1'b1 : strongLowEn[i] ? 1'b0 :
				extDrive[i] ? extLevel[i] : resHighEn[i] ? 1'b1 :
				resLowEn[i] ? 1'b0 : float_r;
		end
	end
endmodule
`default_nettype wire
